/* hdl/pdel_regs.sv */
/*
  Plane and memory energy-limit register bank.
  Holds power-limit, priority, energy and throttle-time registers for the
  core plane, the uncore plane (client) and the memory domain (server).
  The SERVER parameter picks which domains exist; a register that the build
  leaves out reads as zero and raises the miss flag.
  Limit windows are stored raw; the power control unit does the exponent and
  fraction arithmetic, so the bank never needs a multiplier.
  Assumes single-cycle register reads and writes from the processor on the
  core clock, and per-cycle energy and throttle inputs from the power
  control unit on the same clock. The time tick also comes from that clock
  domain, so no input passes a synchroniser.
  Counters are cleared only by reset; software cannot zero an
  accumulator.
*/
// How it works
// - Plane limit bits 14:0 hold average power limit in power units.
// - Plane limit bit 15 enables the limit.
// - Plane limit bit 16 permits clamping below requested state.
// - Plane window bits 23:17: exponent 21:17, fraction 23:22, time units.
// - Plane lock bit 31 blocks limit and priority writes until reset.
// - Each plane's lock acts only on its own registers.
// - Energy registers read-only, 32-bit energy count since clear.
// - Energy counters refresh about every millisecond.
// - Priority register holds 5-bit level, 31 highest, sent onward.
// - Reset priorities favour the uncore plane over the core plane.
// - Core throttle-time is read-only accumulated throttled time.
// - Core throttle-time only on server; uncore registers only on client.
// - Memory limit bits 14:0 power limit, bit 15 enable.
// - Memory window bits 23:17 encoded like plane windows.
// - Memory lock bit 31 blocks memory limit writes until reset.
// - Memory info: TDP 14:0, minimum 30:16, maximum 46:32.
// - Memory info bits 53:48 give largest programmable window.
// - Memory throttle-time is read-only accumulated throttled time.
// - Memory registers exist only on server configurations.
// - Time unit field resets to 1010b.
// - Power limit sits at offset 0 of each domain.
// - Energy count sits at offset 1 of each domain.
`timescale 1ns/1ps
`default_nettype none

module pdel_regs
  import pdel_pkg::*;
#(
  parameter bit          SERVER      = 1'b0,
  parameter int          REFRESH_CYC = pdel_pkg::PDEL_REFRESH_CYC,
  parameter logic [14:0] MEM_TDP     = 15'h0100,
  parameter logic [14:0] MEM_MIN     = 15'h0040,
  parameter logic [14:0] MEM_MAX     = 15'h0200,
  parameter logic [5:0]  MEM_MAX_WIN = 6'h10
) (
  input  wire logic        CLOCK_I,           // Core clock, 10 MHz
  input  wire logic        RST_I,             // Synchronous reset, active high
  input  wire logic [7:0]  REG_IDX_I,         // Register index
  input  wire logic        REG_WR_I,          // Write strobe, one cycle
  input  wire logic        REG_RD_I,          // Read strobe, one cycle
  input  wire logic [63:0] REG_WDATA_I,       // Write data
  output logic      [63:0] REG_RDATA_O,       // Read data, valid cycle after read
  output logic             REG_RVALID_O,      // Read data valid pulse
  output logic             REG_MISS_O,        // Read hit no register
  input  wire logic [15:0] CORE_ENERGY_I,     // Core plane energy this cycle
  input  wire logic [15:0] UNCORE_ENERGY_I,   // Uncore plane energy this cycle
  input  wire logic [15:0] MEM_ENERGY_I,      // Memory energy this cycle
  input  wire logic        CORE_THROTTLE_I,   // Core plane below requested state
  input  wire logic        MEM_THROTTLE_I,    // Memory domain throttled
  input  wire logic        TIME_TICK_I,       // One pulse per time unit
  output logic      [31:0] CORE_LIMIT_O,      // Core limit settings
  output logic      [31:0] UNCORE_LIMIT_O,    // Uncore limit settings
  output logic      [31:0] MEM_LIMIT_O,       // Memory limit settings
  output logic      [4:0]  CORE_PRIO_O,       // Core priority level
  output logic      [4:0]  UNCORE_PRIO_O      // Uncore priority level
);

  localparam int CW = $clog2(REFRESH_CYC + 1);

  function automatic logic [31:0] merge_limit(input logic [31:0] old_v, input logic [63:0] wd,
                                              input logic [31:0] mask);
    merge_limit = old_v[PDEL_LIM_LOCK] ? old_v : (wd[31:0] & mask);
  endfunction

  // Index decode shared by every domain register select; the unit register compares its index directly
  function automatic logic reg_at(input logic [7:0] idx, input logic [7:0] base,
                                  input logic [7:0] off);
    reg_at = (idx == base + off);
  endfunction

  // Software-visible settings
  logic [31:0]   core_lim_ff;
  logic [31:0]   uncore_lim_ff;
  logic [31:0]   mem_lim_ff;
  logic [4:0]    core_prio_ff;
  logic [4:0]    uncore_prio_ff;
  // Published energy snapshots and the running sums behind them
  logic [31:0]   core_en_ff;
  logic [31:0]   uncore_en_ff;
  logic [31:0]   mem_en_ff;
  logic [31:0]   core_acc_ff;
  logic [31:0]   uncore_acc_ff;
  logic [31:0]   mem_acc_ff;
  // Throttle-time accumulators
  logic [31:0]   core_thr_ff;
  logic [31:0]   mem_thr_ff;
  // Refresh divider and read return path
  logic [CW-1:0] tick_cnt_ff;
  logic [63:0]   rdata_ff;
  logic          rvalid_ff;
  logic          miss_ff;

  wire refresh = (tick_cnt_ff == CW'(REFRESH_CYC - 1));
  wire uncore_on = !SERVER;
  wire mem_on    = SERVER;

  // Register selects; each build masks off the domains it lacks
  wire hit_core_lim  = reg_at(REG_IDX_I, PDEL_BASE_CORE, PDEL_OFF_LIMIT);
  wire hit_core_en   = reg_at(REG_IDX_I, PDEL_BASE_CORE, PDEL_OFF_ENERGY);
  wire hit_core_pol  = reg_at(REG_IDX_I, PDEL_BASE_CORE, PDEL_OFF_POLICY);
  wire hit_core_thr  = SERVER && reg_at(REG_IDX_I, PDEL_BASE_CORE, PDEL_OFF_THROTTLE);
  wire hit_unc_lim   = uncore_on && reg_at(REG_IDX_I, PDEL_BASE_UNCORE, PDEL_OFF_LIMIT);
  wire hit_unc_en    = uncore_on && reg_at(REG_IDX_I, PDEL_BASE_UNCORE, PDEL_OFF_ENERGY);
  wire hit_unc_pol   = uncore_on && reg_at(REG_IDX_I, PDEL_BASE_UNCORE, PDEL_OFF_POLICY);
  wire hit_mem_lim   = mem_on && reg_at(REG_IDX_I, PDEL_BASE_MEM, PDEL_OFF_LIMIT);
  wire hit_mem_en    = mem_on && reg_at(REG_IDX_I, PDEL_BASE_MEM, PDEL_OFF_ENERGY);
  wire hit_mem_thr   = mem_on && reg_at(REG_IDX_I, PDEL_BASE_MEM, PDEL_OFF_THROTTLE);
  wire hit_mem_info  = mem_on && reg_at(REG_IDX_I, PDEL_BASE_MEM, PDEL_OFF_INFO);
  wire hit_unit      = REG_IDX_I == PDEL_IDX_UNIT;

  wire [63:0] unit_val = {44'h0, PDEL_TIME_UNIT_RST, 3'h0, PDEL_ENERGY_UNIT_RST,
                          4'h0, PDEL_POWER_UNIT_RST};
  wire [63:0] info_val = {10'h0, MEM_MAX_WIN, 1'b0, MEM_MAX, 1'b0, MEM_MIN,
                          1'b0, MEM_TDP};

  wire any_hit = hit_core_lim | hit_core_en | hit_core_pol | hit_core_thr | hit_unc_lim |
                 hit_unc_en | hit_unc_pol | hit_mem_lim | hit_mem_en | hit_mem_thr |
                 hit_mem_info | hit_unit;

  wire [63:0] rd_mux =
      hit_core_lim ? {32'h0, core_lim_ff} :
      hit_core_en  ? {32'h0, core_en_ff} :
      hit_core_pol ? {59'h0, core_prio_ff} :
      hit_core_thr ? {32'h0, core_thr_ff} :
      hit_unc_lim  ? {32'h0, uncore_lim_ff} :
      hit_unc_en   ? {32'h0, uncore_en_ff} :
      hit_unc_pol  ? {59'h0, uncore_prio_ff} :
      hit_mem_lim  ? {32'h0, mem_lim_ff} :
      hit_mem_en   ? {32'h0, mem_en_ff} :
      hit_mem_thr  ? {32'h0, mem_thr_ff} :
      hit_mem_info ? info_val :
      hit_unit     ? unit_val : 64'h0;

  // Fields 14:0, 15, 16 (plane only), 23:17 (exponent 21:17, fraction 23:22), 31 are kept; the
  // window is stored as written and decoded by the power control unit.
  wire core_lim_we    = REG_WR_I && hit_core_lim;
  wire uncore_lim_we  = REG_WR_I && hit_unc_lim;
  wire mem_lim_we     = REG_WR_I && hit_mem_lim;
  // Each plane's priority is guarded only by its own plane's lock
  wire core_prio_we   = REG_WR_I && hit_core_pol && !core_lim_ff[PDEL_LIM_LOCK];
  wire uncore_prio_we = REG_WR_I && hit_unc_pol && !uncore_lim_ff[PDEL_LIM_LOCK];

  // The lock is judged on the stored value, so the write that sets the lock
  // still lands and only later writes bounce off it.
  wire [31:0] nxt_core_lim = core_lim_we ?
      merge_limit(core_lim_ff, REG_WDATA_I, PDEL_PLANE_LIM_MASK) : core_lim_ff;
  wire [31:0] nxt_uncore_lim = uncore_lim_we ?
      merge_limit(uncore_lim_ff, REG_WDATA_I, PDEL_PLANE_LIM_MASK) : uncore_lim_ff;
  wire [31:0] nxt_mem_lim = mem_lim_we ?
      merge_limit(mem_lim_ff, REG_WDATA_I, PDEL_MEM_LIM_MASK) : mem_lim_ff;
  wire [4:0] nxt_core_prio = core_prio_we ?
      REG_WDATA_I[PDEL_PRIO_W-1:0] : core_prio_ff;
  wire [4:0] nxt_uncore_prio = uncore_prio_we ?
      REG_WDATA_I[PDEL_PRIO_W-1:0] : uncore_prio_ff;

  // Running sums wrap modulo 2^32 by plain overflow; a domain that the build
  // leaves out keeps its sum at zero so nothing stale can surface.
  wire [31:0]   nxt_core_acc   = core_acc_ff + {16'h0, CORE_ENERGY_I};
  wire [31:0]   nxt_uncore_acc = uncore_on ? uncore_acc_ff + {16'h0, UNCORE_ENERGY_I} : 32'h0;
  wire [31:0]   nxt_mem_acc    = mem_on ? mem_acc_ff + {16'h0, MEM_ENERGY_I} : 32'h0;
  wire [CW-1:0] nxt_tick_cnt   = refresh ? '0 : tick_cnt_ff + 1'b1;

  // Throttle time counts time units spent throttled; wraps silently
  wire        core_thr_inc = SERVER && TIME_TICK_I && CORE_THROTTLE_I;
  wire        mem_thr_inc  = mem_on && TIME_TICK_I && MEM_THROTTLE_I;
  wire [31:0] nxt_core_thr = core_thr_ff + 32'h1;
  wire [31:0] nxt_mem_thr  = mem_thr_ff + 32'h1;

  // Unmapped and build-hidden indices answer with zero data and a miss
  wire rd_miss = REG_RD_I && !any_hit;

  // Limit registers
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      core_lim_ff <= 32'h0;
    end else begin
      core_lim_ff <= nxt_core_lim;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      uncore_lim_ff <= 32'h0;
    end else begin
      uncore_lim_ff <= nxt_uncore_lim;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      mem_lim_ff <= 32'h0;
    end else begin
      mem_lim_ff <= nxt_mem_lim;
    end
  end

  // Priority registers
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      core_prio_ff <= PDEL_CORE_PRIO_RST;
    end else begin
      core_prio_ff <= nxt_core_prio;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      uncore_prio_ff <= PDEL_UNCORE_PRIO_RST;
    end else begin
      uncore_prio_ff <= nxt_uncore_prio;
    end
  end

  // Refresh divider: one pulse every REFRESH_CYC cycles
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
    end
  end

  // Running sums
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      core_acc_ff <= 32'h0;
    end else begin
      core_acc_ff <= nxt_core_acc;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      uncore_acc_ff <= 32'h0;
    end else begin
      uncore_acc_ff <= nxt_uncore_acc;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      mem_acc_ff <= 32'h0;
    end else begin
      mem_acc_ff <= nxt_mem_acc;
    end
  end

  // Energy accumulates every cycle but is published once per interval, so
  // software sees a value that is stable for about a millisecond.
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      core_en_ff <= 32'h0;
    end else if (refresh) begin
      core_en_ff <= core_acc_ff;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      uncore_en_ff <= 32'h0;
    end else if (refresh) begin
      uncore_en_ff <= uncore_acc_ff;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      mem_en_ff <= 32'h0;
    end else if (refresh) begin
      mem_en_ff <= mem_acc_ff;
    end
  end

  // Throttle counters
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      core_thr_ff <= 32'h0;
    end else if (core_thr_inc) begin
      core_thr_ff <= nxt_core_thr;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      mem_thr_ff <= 32'h0;
    end else if (mem_thr_inc) begin
      mem_thr_ff <= nxt_mem_thr;
    end
  end

  // Read return path: data holds until the next read
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      rdata_ff <= 64'h0;
    end else if (REG_RD_I) begin
      rdata_ff <= rd_mux;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= REG_RD_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      miss_ff <= 1'b0;
    end else begin
      miss_ff <= rd_miss;
    end
  end

  assign REG_RDATA_O    = rdata_ff;
  assign REG_RVALID_O   = rvalid_ff;
  assign REG_MISS_O     = miss_ff;
  assign CORE_LIMIT_O   = core_lim_ff;
  assign UNCORE_LIMIT_O = uncore_lim_ff;
  assign MEM_LIMIT_O    = mem_lim_ff;
  assign CORE_PRIO_O    = core_prio_ff;
  assign UNCORE_PRIO_O  = uncore_prio_ff;

endmodule // pdel_regs

`default_nettype wire

/* inc/pdel_pkg.sv */
/*
  Shared constants for the plane and memory energy-limit register bank:
  register indices, field positions, reset values and timing counts.
  Assumes a 10 MHz core clock and a register access path that carries
  a register index and up to 64 bits of data.
*/
`default_nettype none
package pdel_pkg;

  // Register indices: domain base plus offset within the domain; the unit index stands alone
  localparam logic [7:0] PDEL_OFF_LIMIT    = 8'h00;
  localparam logic [7:0] PDEL_OFF_ENERGY   = 8'h01;
  localparam logic [7:0] PDEL_OFF_POLICY   = 8'h02;
  localparam logic [7:0] PDEL_OFF_THROTTLE = 8'h03;
  localparam logic [7:0] PDEL_OFF_INFO     = 8'h04;
  localparam logic [7:0] PDEL_BASE_MEM     = 8'h18;
  localparam logic [7:0] PDEL_BASE_CORE    = 8'h38;
  localparam logic [7:0] PDEL_BASE_UNCORE  = 8'h40;
  localparam logic [7:0] PDEL_IDX_UNIT     = 8'h06;

  // Limit register fields
  localparam int PDEL_LIM_POWER_LSB = 0;
  localparam int PDEL_LIM_POWER_W   = 15;
  localparam int PDEL_LIM_ENABLE    = 15;
  localparam int PDEL_LIM_CLAMP     = 16;
  localparam int PDEL_LIM_WIN_LSB   = 17;
  localparam int PDEL_LIM_WIN_W     = 7;
  localparam int PDEL_LIM_EXP_W     = 5;
  localparam int PDEL_LIM_FRAC_LSB  = 22;
  localparam int PDEL_LIM_LOCK      = 31;
  localparam logic [31:0] PDEL_PLANE_LIM_MASK = 32'h80FF_FFFF;
  localparam logic [31:0] PDEL_MEM_LIM_MASK   = 32'h80FE_FFFF;

  // Policy fields
  localparam int PDEL_PRIO_W = 5;
  localparam logic [4:0] PDEL_CORE_PRIO_RST   = 5'h00;
  localparam logic [4:0] PDEL_UNCORE_PRIO_RST = 5'h10;

  // Unit register fields
  localparam int PDEL_UNIT_TIME_LSB = 16;
  localparam logic [3:0]  PDEL_TIME_UNIT_RST = 4'hA;
  localparam logic [3:0]  PDEL_POWER_UNIT_RST = 4'h3;
  localparam logic [4:0]  PDEL_ENERGY_UNIT_RST = 5'h10;

  // Memory info fields
  localparam int PDEL_INFO_MIN_LSB = 16;
  localparam int PDEL_INFO_MAX_LSB = 32;
  localparam int PDEL_INFO_WIN_LSB = 48;

  // Timing: energy refresh interval
  localparam int PDEL_CLK_HZ       = 10_000_000;
  localparam int PDEL_REFRESH_US   = 1000;
  localparam int PDEL_REFRESH_CYC  = PDEL_CLK_HZ / 1_000_000 * PDEL_REFRESH_US;

endpackage : pdel_pkg
`default_nettype wire

/* bench/pdel_regs_sva.sv */
/* Port-level assertions for the energy-limit register bank.
   Assumes pdel_pkg is compiled first; bound to every pdel_regs. */
`timescale 1ns/1ps
`default_nettype none
module pdel_regs_sva
  import pdel_pkg::*;
#(
  parameter bit SERVER = 1'b0
) (
  input wire logic        CLOCK_I,       // Core clock
  input wire logic        RST_I,         // Sync reset
  input wire logic [7:0]  REG_IDX_I,     // Index
  input wire logic        REG_WR_I,      // Write strobe
  input wire logic        REG_RD_I,      // Read strobe
  input wire logic [63:0] REG_WDATA_I,   // Write data
  input wire logic [63:0] REG_RDATA_O,   // Read data
  input wire logic        REG_RVALID_O,  // Read valid
  input wire logic        REG_MISS_O,    // Unmapped read
  input wire logic [31:0] CORE_LIMIT_O,  // Core limit
  input wire logic [31:0] MEM_LIMIT_O,   // Memory limit
  input wire logic [4:0]  CORE_PRIO_O    // Core priority
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // Lock is judged on the registered copy, which is what the write sees
  wire logic core_wr = REG_WR_I && REG_IDX_I == PDEL_BASE_CORE && !CORE_LIMIT_O[31];
  wire logic prio_wr = REG_WR_I && REG_IDX_I == (PDEL_BASE_CORE + PDEL_OFF_POLICY) && !CORE_LIMIT_O[31];
  wire logic mem_wr  = SERVER && REG_WR_I && REG_IDX_I == PDEL_BASE_MEM && !MEM_LIMIT_O[31];
  property p_rd_answer; REG_RD_I |=> REG_RVALID_O; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
  property p_rd_idle; !REG_RD_I |=> !REG_RVALID_O && !REG_MISS_O; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("valid without read");
  property p_miss; REG_MISS_O |-> REG_RVALID_O && REG_RDATA_O == 64'h0; endproperty
  a_miss: assert property (p_miss) else $error("miss with nonzero data");
  property p_core_wr; core_wr |=> CORE_LIMIT_O == ($past(REG_WDATA_I[31:0]) & PDEL_PLANE_LIM_MASK); endproperty
  a_core_wr: assert property (p_core_wr) else $error("core limit write lost");
  property p_prio_wr; prio_wr |=> CORE_PRIO_O == $past(REG_WDATA_I[4:0]); endproperty
  a_prio_wr: assert property (p_prio_wr) else $error("priority write lost");
  property p_mem_wr; mem_wr |=> MEM_LIMIT_O == ($past(REG_WDATA_I[31:0]) & PDEL_MEM_LIM_MASK); endproperty
  a_mem_wr: assert property (p_mem_wr) else $error("memory limit write lost");
  property p_core_lock; CORE_LIMIT_O[31] |=> $stable(CORE_LIMIT_O) && $stable(CORE_PRIO_O); endproperty
  a_core_lock: assert property (p_core_lock) else $error("locked core plane changed");
  property p_mem_lock; MEM_LIMIT_O[31] |=> $stable(MEM_LIMIT_O) [*2]; endproperty
  a_mem_lock: assert property (p_mem_lock) else $error("locked memory limit changed");
  c_miss: cover property (REG_MISS_O);
  c_core_locked_wr: cover property (CORE_LIMIT_O[31] && REG_WR_I && REG_IDX_I == PDEL_BASE_CORE);
  c_mem_locked_wr: cover property (MEM_LIMIT_O[31] && REG_WR_I && REG_IDX_I == PDEL_BASE_MEM);
endmodule  // pdel_regs_sva
bind pdel_regs pdel_regs_sva #(.SERVER(SERVER)) i_sva (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .REG_IDX_I(REG_IDX_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
  .REG_MISS_O(REG_MISS_O), .CORE_LIMIT_O(CORE_LIMIT_O), .MEM_LIMIT_O(MEM_LIMIT_O), .CORE_PRIO_O(CORE_PRIO_O));
`default_nettype wire

/* bench/pdel_regs_test.sv */
/* Self-checking bench for the energy-limit register bank, server and client builds.
   Assumes pdel_pkg and the design are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module pdel_regs_test;
  localparam int RC = 8;  // Short refresh keeps the run brief
  typedef struct {logic [7:0] idx; logic [63:0] wd; logic [63:0] ex; logic ms;} pdel_row_t;
  logic        clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, cthr_i = 0, mthr_i = 0, tick_i = 0, rvalid, miss, m;
  logic [7:0]  idx_i = 8'h00;
  logic [63:0] wdata_i = 64'h0, rdata, d0, d1, d2;
  logic [31:0] core_lim, mem_lim, uncore_lim, uncore_lim_c;
  logic [63:0] rdata_c;
  logic        miss_c;
  logic [4:0]  core_prio_c, uncore_prio_c;
  logic [4:0]  core_prio, uncore_prio;
  int          error_cnt = 0, cmp_count = 0;
  pdel_row_t   rows [6] = '{
    '{8'h38, 64'hFFFF_FFFF_7FFF_FFFF, 64'h00FF_FFFF, 1'b0},
    '{8'h3A, 64'h3F, 64'h1F, 1'b0},
    '{8'h18, 64'h7FFF_FFFF, 64'h00FE_FFFF, 1'b0},
    '{8'h06, 64'h0, 64'h000A_1003, 1'b0},
    '{8'h1C, 64'hFFFF_FFFF_FFFF_FFFF, 64'h0010_0200_0040_0100, 1'b0},
    '{8'h40, 64'h1, 64'h0, 1'b1}};
  pdel_regs #(.SERVER(1'b1), .REFRESH_CYC(RC)) i_dut (
    .CLOCK_I(clk_i), .RST_I(rst_i), .REG_IDX_I(idx_i), .REG_WR_I(wr_i), .REG_RD_I(rd_i),
    .REG_WDATA_I(wdata_i), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .REG_MISS_O(miss),
    .CORE_ENERGY_I(16'h0003), .UNCORE_ENERGY_I(16'h0007), .MEM_ENERGY_I(16'h0005),
    .CORE_THROTTLE_I(cthr_i), .MEM_THROTTLE_I(mthr_i), .TIME_TICK_I(tick_i),
    .CORE_LIMIT_O(core_lim), .UNCORE_LIMIT_O(uncore_lim), .MEM_LIMIT_O(mem_lim),
    .CORE_PRIO_O(core_prio), .UNCORE_PRIO_O(uncore_prio));
  // Client build on the same bus: plane independence and what a client hides
  pdel_regs #(.SERVER(1'b0), .REFRESH_CYC(RC)) i_dut_cl (
    .CLOCK_I(clk_i), .RST_I(rst_i), .REG_IDX_I(idx_i), .REG_WR_I(wr_i), .REG_RD_I(rd_i),
    .REG_WDATA_I(wdata_i), .REG_RDATA_O(rdata_c), .REG_RVALID_O(), .REG_MISS_O(miss_c),
    .CORE_ENERGY_I(16'h0003), .UNCORE_ENERGY_I(16'h0007), .MEM_ENERGY_I(16'h0005),
    .CORE_THROTTLE_I(cthr_i), .MEM_THROTTLE_I(mthr_i), .TIME_TICK_I(tick_i),
    .CORE_LIMIT_O(), .UNCORE_LIMIT_O(uncore_lim_c), .MEM_LIMIT_O(),
    .CORE_PRIO_O(core_prio_c), .UNCORE_PRIO_O(uncore_prio_c));
  initial forever #50 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] ex);
    cmp_count++;
    if (seen !== ex) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    idx_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [63:0] d, output logic ms);
    @(posedge clk_i);
    rd_i <= 1'b1;
    idx_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk("rvalid", rvalid, 64'h1);
    d = rdata;
    ms = miss;
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk_i);
    error_cnt++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("core_prio", core_prio, 64'h0);
    chk("uncore_prio", uncore_prio, 64'h10);
    foreach (rows[i]) begin
      wr(rows[i].idx, rows[i].wd);
      rd(rows[i].idx, d0, m);
      chk("row data", d0, rows[i].ex);
      chk("row miss", m, rows[i].ms);
    end
    chk("server uncore limit", uncore_lim, 64'h0);
    chk("client uncore limit", uncore_lim_c, 64'h1);
    wr(8'h38, 64'h8000_0010);
    wr(8'h38, 64'h0);
    wr(8'h3A, 64'h5);
    rd(8'h38, d0, m);
    chk("core limit locked", d0, 64'h8000_0010);
    rd(8'h3A, d0, m);
    chk("core prio locked", d0, 64'h1F);
    wr(8'h18, 64'h8000_0001);
    wr(8'h18, 64'h0);
    rd(8'h18, d0, m);
    chk("mem limit locked", d0, 64'h8000_0001);
    for (int k = 0; k < 2; k++) begin
      rd(k ? 8'h19 : 8'h39, d0, m);
      repeat (RC - 2) @(posedge clk_i);
      rd(k ? 8'h19 : 8'h39, d1, m);
      chk("energy step", d1 - d0, k ? 64'h28 : 64'h18);
    end
    rd(8'h3B, d0, m);
    rd(8'h1B, d1, m);
    // Ticks while not throttled must not count
    for (int j = 0; j < 6; j++) begin
      @(posedge clk_i);
      tick_i <= 1'b1;
      cthr_i <= (j < 4);
      mthr_i <= (j < 2);
      @(posedge clk_i);
      tick_i <= 1'b0;
    end
    rd(8'h3B, d2, m);
    chk("core throttle", d2 - d0, 64'h4);
    rd(8'h1B, d2, m);
    chk("mem throttle", d2 - d1, 64'h2);
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk("limit after reset", core_lim, 64'h0);
    wr(8'h38, 64'h10);
    rd(8'h38, d0, m);
    chk("limit unlocked", d0, 64'h10);
    wr(8'h40, 64'h8000_0020);
    wr(8'h42, 64'h3);
    wr(8'h3A, 64'h7);
    #1;
    chk("client uncore locked", uncore_lim_c, 64'h8000_0020);
    chk("client uncore prio held", uncore_prio_c, 64'h10);
    chk("client core prio free", core_prio_c, 64'h7);
    rd(8'h1B, d0, m);
    chk("client memory hidden", miss_c, 64'h1);
    chk("client miss data", rdata_c, 64'h0);
    rd(8'h3B, d0, m);
    chk("client throttle hidden", miss_c, 64'h1);
    print_verdict;
  end
endmodule  // pdel_regs_test
`default_nettype wire
